// >>> core/pog_map.svh
// pog_map.svh: register offsets, field positions, codes and timing figures
// assumes: included by bare name by the package and the top module
`ifndef POG_MAP_SVH
`define POG_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte offsets on the module register port)
// ----------------------------------------------------------------
`define POG_OFS_SETUP      8'h0C
`define POG_OFS_CLK_HI     8'h0E
`define POG_OFS_CLK_LO     8'h10
`define POG_OFS_PATCH_PTR  8'h12
`define POG_OFS_PATCH_HI   8'h14
`define POG_OFS_PATCH_LO   8'h16
`define POG_OFS_HOST_ADDR  8'h18
`define POG_OFS_HOST_DATA  8'h1A

// ----------------------------------------------------------------
// output_setup fields
// ----------------------------------------------------------------
`define POG_TSE_BIT        15
`define POG_INH_BIT        14
`define POG_MPW_HI         11
`define POG_MPW_LO         8
`define POG_LWC_HI         7
`define POG_LWC_LO         4
`define POG_PSC_HI         3
`define POG_PSC_LO         0
`define POG_SETUP_RST      16'h0000

// ----------------------------------------------------------------
// packing size codes and marker width codes
// ----------------------------------------------------------------
`define POG_PSC_1BIT       4'h0
`define POG_PSC_2BIT       4'h8
`define POG_PSC_4BIT       4'hC
`define POG_PSC_8BIT       4'hE
`define POG_PSC_16BIT      4'hF
`define POG_MPW_SHORT      4'h2
`define POG_MPW_MID        4'h4
`define POG_MPW_LONG       4'h8
`define POG_WORD_BITS      16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define POG_CLK_NS         4
`define POG_STEP_NS        50
`define POG_MK_SHORT_NS    50
`define POG_MK_MID_NS      900
`define POG_MK_LONG_US     800
`define POG_MK_SHORT_CYC   ((`POG_MK_SHORT_NS + `POG_CLK_NS - 1) / `POG_CLK_NS)
`define POG_MK_MID_CYC     ((`POG_MK_MID_NS + `POG_CLK_NS - 1) / `POG_CLK_NS)
`define POG_MK_LONG_CYC    ((`POG_MK_LONG_US * 1000 + `POG_CLK_NS - 1) / `POG_CLK_NS)

`endif

// >>> core/pog_pkg.sv
// pog_pkg.sv: types shared by the pattern output configuration block
// assumes: pog_map.svh sits on the include path
`include "pog_map.svh"

package pog_pkg;

	// ----------------------------------------------------------------
	// fetch sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		POG_FS_IDLE,
		POG_FS_ISSUE,
		POG_FS_WAIT,
		POG_FS_DONE
	} pog_fetch_t;

endpackage : pog_pkg

// >>> core/pog_fifo.sv
// pog_fifo.sv: small synchronous fifo between memory fetch and unpacking
// assumes: single clock, flush empties the fifo in one edge
`timescale 1ns/1ps

module pog_fifo #(
	parameter int unsigned WIDTH = 33,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = store_r[rd_ptr_r];

	always_ff @(posedge clk) begin
		if (push) begin
			store_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else if (flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
			if (pop) rd_ptr_r <= rd_ptr_r + AW'(1);
			if (push && !pop) count_r <= count_r + (AW+1)'(1);
			else if (pop && !push) count_r <= count_r - (AW+1)'(1);
		end
	end

endmodule : pog_fifo

// >>> core/pog_mem.sv
// pog_mem.sv: pattern memory, 32-bit words, halfword write enables
// assumes: port a is the host side (read and write), port b reads only
`timescale 1ns/1ps

module pog_mem #(
	parameter int unsigned AW = 15
) (
	input  wire logic          clk,
	input  wire logic [AW-1:0] a_addr,
	input  wire logic [1:0]    a_we,
	input  wire logic [31:0]   a_wdata,
	output logic      [31:0]   a_rdata,
	input  wire logic [AW-1:0] b_addr,
	output logic      [31:0]   b_rdata
);
	logic [31:0] cell_r [2**AW];

	always_ff @(posedge clk) begin
		if (a_we[0]) cell_r[a_addr][15:0] <= a_wdata[15:0];
		if (a_we[1]) cell_r[a_addr][31:16] <= a_wdata[31:16];
		a_rdata <= cell_r[a_addr];
		b_rdata <= cell_r[b_addr];
	end

endmodule : pog_mem

// >>> core/pog_top.sv
// pog_top.sv: output configuration registers and pattern output path
// assumes: one 250 MHz clock; run, mode and sequence bounds come from
// the control logic outside as plain inputs
//
// Functional notes
// R01: word mode unpacks each memory word into output words of coded size
// R02: 2, 4, 8 bit groups go to channels 1/9, 1/5/9/13, odd; 16 direct
// R03: final memory word emits only 16 minus last word count words
// R04: packing code all ones ignores the last word count
// R05: marker pulse width code selects 50ns, 900ns or 800us
// R06: tristate enable bit makes outputs follow the word's tristate bits; shown patch data (R11) keeps all 16 enables on
// R07: host writes output_setup only while idle
// R08: internal clock period is (32-bit value + 1) times 50ns
// R09: host keeps period value above zero when internal clock selected
// R10: patch pointer write stores 32-bit patch data at that pointer
// R11: continuous cycling also shows patch data at the output port
// R12: patches take effect only while running
// R13: patch data registers are writable at any time
// R14: host data access uses the 16-bit address in host_memory_address
// R15: host data access bumps the address unless inhibit bit is set
// R16: idle with idle view switch on shows memory at host address
// R17: kind bit 1 selects timing simulator, 0 word generator
// R18: cycle mode bit 1 runs once, 0 cycles continuously
// R19: run bit low means idle; idle-only registers change only then
// R20: unpacking emits the least significant group first
`timescale 1ns/1ps
`include "pog_map.svh"

module pog_top import pog_pkg::*; #(
	parameter int unsigned MK_LONG_CYC = `POG_MK_LONG_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        run_enable,
	input  wire logic        cycle_mode_bit,
	input  wire logic        operating_kind_bit,
	input  wire logic        idle_view_switch,
	input  wire logic [14:0] seq_start_ptr,
	input  wire logic [14:0] seq_end_ptr,
	output logic      [15:0] pat_out,
	output logic      [15:0] pat_oe,
	output logic             word_strobe,
	output logic             marker_pulse,
	output logic             seq_done
);
	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [4:0] groups_of(input logic [3:0] code);
		unique case (code)
			`POG_PSC_1BIT: groups_of = 5'h10;
			`POG_PSC_2BIT: groups_of = 5'h08;
			`POG_PSC_4BIT: groups_of = 5'h04;
			`POG_PSC_8BIT: groups_of = 5'h02;
			default:       groups_of = 5'h01;
		endcase
	endfunction : groups_of

	// group k of width w lands on channel j * (16 / w), lsb group first
	function automatic logic [15:0] unpack(input logic [15:0] word,
			input logic [3:0] code, input logic [4:0] k);
		int w;
		int stride;
		logic [15:0] res;
		w = `POG_WORD_BITS / int'(groups_of(code));
		stride = `POG_WORD_BITS / w;
		res = 16'h0000;
		for (int j = 0; j < `POG_WORD_BITS; j++) begin
			if (j < w) res[j * stride] = word[int'(k) * w + j]; // R01 R02 R20
		end
		unpack = res;
	endfunction : unpack

	function automatic logic [15:0] half_of(input logic [31:0] w,
			input logic hi);
		half_of = hi ? w[31:16] : w[15:0];
	endfunction : half_of

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] setup_r;
	logic [15:0] clk_hi_r;
	logic [15:0] clk_lo_r;
	logic [15:0] patch_ptr_r;
	logic [15:0] patch_hi_r;
	logic [15:0] patch_lo_r;
	logic [15:0] host_addr_r;
	logic [15:0] rd_hold_r;
	logic        rd_pend_r;
	logic        rd_user_r;
	logic        half_q_r;
	logic [31:0] a_rdata;
	logic [31:0] b_rdata;

	wire hit_setup = reg_addr == `POG_OFS_SETUP;
	wire hit_clk_hi = reg_addr == `POG_OFS_CLK_HI;
	wire hit_clk_lo = reg_addr == `POG_OFS_CLK_LO;
	wire hit_ptr = reg_addr == `POG_OFS_PATCH_PTR;
	wire hit_phi = reg_addr == `POG_OFS_PATCH_HI;
	wire hit_plo = reg_addr == `POG_OFS_PATCH_LO;
	wire hit_haddr = reg_addr == `POG_OFS_HOST_ADDR;
	wire hit_hdata = reg_addr == `POG_OFS_HOST_DATA;

	wire setup_we = reg_wr && hit_setup && !run_enable; // R07 R19
	wire patch_go = reg_wr && hit_ptr && run_enable; // R10 R12
	wire patch_show = patch_go && !cycle_mode_bit; // R11 R18
	wire user_wr = reg_wr && hit_hdata; // R14
	wire user_acc = (reg_wr || reg_rd) && hit_hdata;
	wire step_inh = setup_r[`POG_INH_BIT];
	wire tse = setup_r[`POG_TSE_BIT];
	wire [3:0] psc = setup_r[`POG_PSC_HI:`POG_PSC_LO];
	wire [3:0] lwc = setup_r[`POG_LWC_HI:`POG_LWC_LO];
	wire [3:0] mpw = setup_r[`POG_MPW_HI:`POG_MPW_LO];

	wire [15:0] rd_mux =
		hit_setup ? setup_r :
		hit_clk_hi ? clk_hi_r :
		hit_clk_lo ? clk_lo_r :
		hit_ptr ? patch_ptr_r :
		hit_phi ? patch_hi_r :
		hit_plo ? patch_lo_r :
		hit_haddr ? host_addr_r : 16'h0000;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_r     <= `POG_SETUP_RST;
			clk_hi_r    <= 16'h0000;
			clk_lo_r    <= 16'h0000;
			patch_ptr_r <= 16'h0000;
			patch_hi_r  <= 16'h0000;
			patch_lo_r  <= 16'h0000;
		end else begin
			if (setup_we) setup_r <= reg_wdata;
			if (reg_wr && hit_clk_hi) clk_hi_r <= reg_wdata; // R08
			if (reg_wr && hit_clk_lo) clk_lo_r <= reg_wdata; // R08
			if (reg_wr && hit_ptr) patch_ptr_r <= reg_wdata;
			if (reg_wr && hit_phi) patch_hi_r <= reg_wdata; // R13
			if (reg_wr && hit_plo) patch_lo_r <= reg_wdata; // R13
		end
	end

	// host address: direct write, else step after each data access unless inhibit bit is set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_addr_r <= 16'h0000;
		end else if (reg_wr && hit_haddr) begin
			host_addr_r <= reg_wdata;
		end else if (user_acc && !step_inh) begin
			host_addr_r <= host_addr_r + 16'h0001; // R15
		end
	end

	// read answer two edges after the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_hold_r  <= 16'h0000;
			rd_pend_r  <= 1'b0;
			rd_user_r  <= 1'b0;
			half_q_r   <= 1'b0;
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			rd_hold_r  <= rd_mux;
			rd_pend_r  <= reg_rd;
			rd_user_r  <= hit_hdata;
			half_q_r   <= host_addr_r[0];
			reg_rvalid <= rd_pend_r;
			if (rd_pend_r) begin
				reg_rdata <= rd_user_r ? half_of(a_rdata, half_q_r) // R14
					: rd_hold_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// pattern memory
	// ----------------------------------------------------------------
	logic [14:0] fetch_ptr_r;

	wire [14:0] a_addr = patch_go ? reg_wdata[14:0] : host_addr_r[15:1];
	wire [1:0] a_we = patch_go ? 2'b11 : // R10
		user_wr ? (host_addr_r[0] ? 2'b10 : 2'b01) : 2'b00; // R14
	wire [31:0] a_wdata = patch_go ? {patch_hi_r, patch_lo_r}
		: {reg_wdata, reg_wdata};

	pog_mem #(.AW(15)) u_mem (
		.clk     (clk),
		.a_addr  (a_addr),
		.a_we    (a_we),
		.a_wdata (a_wdata),
		.a_rdata (a_rdata),
		.b_addr  (fetch_ptr_r),
		.b_rdata (b_rdata)
	);

	// ----------------------------------------------------------------
	// internal clock: ns accumulator, ticks every (value + 1) * 50ns
	// ----------------------------------------------------------------
	logic [39:0] acc_r;
	wire [39:0] period_ns = (40'({clk_hi_r, clk_lo_r}) + 40'h1)
		* 40'(`POG_STEP_NS); // R08
	wire [39:0] acc_sum = acc_r + 40'(`POG_CLK_NS);
	wire tick = run_enable && (acc_sum >= period_ns);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) acc_r <= 40'h0;
		else if (!run_enable) acc_r <= 40'h0;
		else acc_r <= tick ? acc_sum - period_ns : acc_sum;
	end

	// ----------------------------------------------------------------
	// fetch sequencer feeding the fifo
	// ----------------------------------------------------------------
	pog_fetch_t fs_r;
	logic       last_r;
	logic       f_in_ready;
	logic       f_out_valid;
	logic [32:0] f_out;
	logic [4:0] grp_left_r;

	wire f_out_ready = tick && (grp_left_r == 5'h00);

	pog_fifo #(.WIDTH(33), .DEPTH(8)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.flush     (!run_enable),
		.in_valid  (fs_r == POG_FS_WAIT),
		.in_ready  (f_in_ready),
		.in_data   ({last_r, b_rdata}),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_r        <= POG_FS_IDLE;
			fetch_ptr_r <= 15'h0000;
			last_r      <= 1'b0;
		end else if (!run_enable) begin
			fs_r        <= POG_FS_IDLE; // R19
			fetch_ptr_r <= seq_start_ptr;
		end else begin
			unique case (fs_r)
				POG_FS_IDLE: fs_r <= POG_FS_ISSUE;
				POG_FS_ISSUE: if (f_in_ready) begin
					fs_r   <= POG_FS_WAIT;
					last_r <= fetch_ptr_r == seq_end_ptr;
				end
				POG_FS_WAIT: begin
					if (last_r) begin
						fetch_ptr_r <= seq_start_ptr;
						fs_r <= cycle_mode_bit ? POG_FS_DONE // R18
							: POG_FS_ISSUE;
					end else begin
						fetch_ptr_r <= fetch_ptr_r + 15'h0001;
						fs_r <= POG_FS_ISSUE;
					end
				end
				POG_FS_DONE: fs_r <= POG_FS_DONE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// unpacking and output port
	// ----------------------------------------------------------------
	logic [15:0] cur_r;
	logic [15:0] tri_r;
	logic [4:0]  grp_idx_r;
	logic [17:0] mk_cnt_r;

	wire direct = operating_kind_bit || (psc == `POG_PSC_16BIT); // R04 R17
	wire [3:0] code = operating_kind_bit ? `POG_PSC_16BIT : psc; // R17
	wire [4:0] total = groups_of(code);
	wire [4:0] n_last = 5'h10 - {1'b0, lwc}; // R03
	wire [4:0] cnt = (f_out[32] && !direct && n_last < total) ? n_last
		: total; // R03
	wire load = f_out_ready && f_out_valid;
	wire step = tick && (grp_left_r != 5'h00);
	wire emit = load || step;
	wire [15:0] emit_word = load ? unpack(f_out[15:0], code, 5'h00)
		: unpack(cur_r, code, grp_idx_r); // R20
	wire [15:0] emit_tri = load ? f_out[31:16] : tri_r;
	wire [15:0] emit_oe = tse ? ~emit_tri : 16'hFFFF; // R06

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_r      <= 16'h0000;
			tri_r      <= 16'h0000;
			grp_idx_r  <= 5'h00;
			grp_left_r <= 5'h00;
		end else if (!run_enable) begin
			grp_left_r <= 5'h00;
		end else if (load) begin
			cur_r      <= f_out[15:0];
			tri_r      <= f_out[31:16];
			grp_idx_r  <= 5'h01;
			grp_left_r <= cnt - 5'h01; // R03
		end else if (step) begin
			grp_idx_r  <= grp_idx_r + 5'h01;
			grp_left_r <= grp_left_r - 5'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pat_out     <= 16'h0000;
			pat_oe      <= 16'h0000;
			word_strobe <= 1'b0;
		end else begin
			word_strobe <= emit || patch_show;
			if (patch_show) begin
				pat_out <= patch_lo_r; // R11
				pat_oe  <= 16'hFFFF;
			end else if (emit) begin
				pat_out <= emit_word; // R01
				pat_oe  <= emit_oe; // R06
			end else if (!run_enable && idle_view_switch) begin
				pat_out <= half_of(a_rdata, half_q_r); // R16
				pat_oe  <= 16'hFFFF;
			end
		end
	end

	// marker pulse: starts on every emitted word, reserved codes give none
	wire [17:0] mk_len =
		(mpw == `POG_MPW_SHORT) ? 18'(`POG_MK_SHORT_CYC) :
		(mpw == `POG_MPW_MID) ? 18'(`POG_MK_MID_CYC) :
		(mpw == `POG_MPW_LONG) ? 18'(MK_LONG_CYC) : 18'h00000; // R05
	wire [17:0] mk_nxt = word_strobe ? mk_len
		: (mk_cnt_r != 18'h00000) ? mk_cnt_r - 18'h00001 : 18'h00000;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mk_cnt_r     <= 18'h00000;
			marker_pulse <= 1'b0;
			seq_done     <= 1'b0;
		end else begin
			mk_cnt_r     <= mk_nxt;
			marker_pulse <= mk_nxt != 18'h00000; // R05
			seq_done     <= run_enable && fs_r == POG_FS_DONE
				&& !f_out_valid && grp_left_r == 5'h00; // R18
		end
	end

endmodule : pog_top

// >>> verification/pog_host.sv
// pog_host.sv: host model for the register port of pog_top
// assumes: requests launched at the falling edge, read answer two edges on
`timescale 1ns/1ps

module pog_host (
	input  wire logic        clk,
	output logic      [7:0]  reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	initial begin
		reg_addr  = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_wdata = 16'h0000;
	end

	// one-cycle write strobe, data released to its inverse
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge clk);
		reg_wr    = 1'b0;
		reg_wdata = ~d;
	endtask : wr

	// answer stands for one cycle, between the first and second edge
	// after the request edge; it is taken in the middle of that cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge clk);
		reg_rd   = 1'b0;
		@(negedge clk);
		d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
	endtask : rd
endmodule : pog_host

// >>> verification/pog_top_chk.sv
// pog_top_chk.sv: port assertions for pog_top
// assumes: bound to pog_top, one clock, rst_n async active low
`timescale 1ns/1ps

module pog_top_chk import pog_pkg::*; #(
	parameter int unsigned MK_LONG_CYC = 20
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        run_enable,
	input wire logic        cycle_mode_bit,
	input wire logic [15:0] pat_out,
	input wire logic [15:0] pat_oe,
	input wire logic        word_strobe,
	input wire logic        marker_pulse,
	input wire logic        seq_done
);
	logic [15:0] setup_r;
	logic [15:0] haddr_r;
	logic [15:0] plo_r;
	logic [31:0] mk_cnt_r;
	wire         ud_acc   = (reg_wr | reg_rd) && reg_addr == 8'h1A;
	wire         patch_wr = reg_wr && reg_addr == 8'h12;
	wire  [3:0]  mpw      = setup_r[11:8];
	wire         mk_ok    = mpw == 4'h2 || mpw == 4'h4 || mpw == 4'h8;
	wire  [31:0] mk_exp   = (mpw == 4'h2) ? 32'h0000000D :
		(mpw == 4'h4) ? 32'h000000E1 : MK_LONG_CYC;

	// mirrors of the registers that the assertions depend on, and a count of marker high cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_r  <= 16'h0000;
			haddr_r  <= 16'h0000;
			plo_r    <= 16'h0000;
			mk_cnt_r <= 32'h00000000;
		end else begin
			if (reg_wr && reg_addr == 8'h0C && !run_enable) setup_r <= reg_wdata;
			if (reg_wr && reg_addr == 8'h16) plo_r <= reg_wdata;
			if (reg_wr && reg_addr == 8'h18) haddr_r <= reg_wdata;
			else if (ud_acc && !setup_r[14]) haddr_r <= haddr_r + 16'h0001;
			mk_cnt_r <= marker_pulse ? mk_cnt_r + 32'h00000001 : 32'h00000000;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_show;
		##1 (pat_out == plo_r && pat_oe == 16'hFFFF && word_strobe);
	endsequence

	AST_READ_ANSWER: assert property (reg_rd |-> ##2 reg_rvalid)
		else $error("read answer missing");
	AST_NO_STRAY: assert property (reg_rvalid |-> $past(reg_rd, 2))
		else $error("read answer without request");
	AST_HADDR_BUMP: assert property (reg_rd && reg_addr == 8'h18
		|-> ##2 reg_rdata == $past(haddr_r, 2))
		else $error("host address wrong");
	AST_SETUP_IDLE: assert property (reg_rd && reg_addr == 8'h0C
		|-> ##2 reg_rdata == $past(setup_r, 2))
		else $error("output setup wrong");
	AST_PATCH_SHOW: assert property (
		patch_wr && run_enable && !cycle_mode_bit |-> s_show)
		else $error("patch word not shown");
	AST_PATCH_IDLE: assert property (
		patch_wr && !run_enable |-> ##1 !word_strobe ##1 !word_strobe)
		else $error("patch shown while idle");
	AST_OE_FULL: assert property (
		word_strobe && !setup_r[15] |-> pat_oe == 16'hFFFF)
		else $error("enables not all on");
	AST_MARKER_LEN: assert property (
		$fell(marker_pulse) && mk_ok |-> mk_cnt_r == mk_exp)
		else $error("marker length wrong");
	AST_DONE_ONCE: assert property (
		seq_done |-> $past(run_enable) && $past(cycle_mode_bit))
		else $error("done outside single pass");
endmodule : pog_top_chk

bind pog_top pog_top_chk #(.MK_LONG_CYC(MK_LONG_CYC)) chk (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .run_enable(run_enable),
	.cycle_mode_bit(cycle_mode_bit), .pat_out(pat_out), .pat_oe(pat_oe),
	.word_strobe(word_strobe), .marker_pulse(marker_pulse),
	.seq_done(seq_done)
);

// >>> verification/tb_pog_top.sv
// tb_pog_top.sv: self-checking bench for pog_top
// assumes: pog_host drives the register port, the rest is driven here
`timescale 1ns/1ps

module tb_pog_top import pog_pkg::*;;
	localparam logic [15:0] PD = 16'h9C5A;
	localparam logic [15:0] PT = 16'h00FF;
	localparam logic [3:0] PSC [6] = '{4'h0, 4'h8, 4'hC, 4'hE, 4'hF, 4'h8};
	localparam logic [3:0] MPW [6] = '{4'h2, 4'h4, 4'h8, 4'h2, 4'h4, 4'h8};
	localparam int W [6] = '{1, 2, 4, 8, 16, 16};
	localparam int N [6] = '{3, 3, 3, 2, 1, 1};

	logic        clk, rst_n, run_enable, cycle_mode_bit;
	logic        operating_kind_bit, idle_view_switch;
	logic [14:0] seq_start_ptr, seq_end_ptr;
	wire  [7:0]  reg_addr;
	wire  [15:0] reg_wdata, reg_rdata, pat_out, pat_oe;
	wire         reg_wr, reg_rd, reg_rvalid, word_strobe;
	wire         marker_pulse, seq_done;
	int          miscompares = 0;
	int          check_count = 0;
	int          cnt, last;

	pog_top #(.MK_LONG_CYC(20)) uut (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .run_enable(run_enable),
		.cycle_mode_bit(cycle_mode_bit),
		.operating_kind_bit(operating_kind_bit),
		.idle_view_switch(idle_view_switch), .seq_start_ptr(seq_start_ptr),
		.seq_end_ptr(seq_end_ptr), .pat_out(pat_out), .pat_oe(pat_oe),
		.word_strobe(word_strobe), .marker_pulse(marker_pulse),
		.seq_done(seq_done)
	);

	pog_host host (
		.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		host.rd(a, d);
		cmp(d, exp);
	endtask : rdc

	// expected channel word for group k of the pattern data
	function automatic logic [15:0] unpk(input int w, input int k);
		logic [15:0] r;
		r = 16'h0000;
		for (int j = 0; j < w; j++) r[j * (16 / w)] = PD[k * w + j];
		return r;
	endfunction : unpk

	task automatic final_report;
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		#150000;
		miscompares++;
		final_report();
	end

	initial begin
		rst_n = 1'b0;
		run_enable = 1'b0;
		cycle_mode_bit = 1'b1;
		operating_kind_bit = 1'b0;
		idle_view_switch = 1'b0;
		seq_start_ptr = 15'h0008;
		seq_end_ptr = 15'h0008;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 12; i <= 24; i += 2) rdc(8'(i), 16'h0000);
		rdc(8'h1E, 16'h0000);
		rdc(8'h0D, 16'h0000);
		for (int i = 12; i <= 24; i += 2) host.wr(8'(i), {8'(i), 8'hA5});
		for (int i = 12; i <= 24; i += 2) rdc(8'(i), {8'(i), 8'hA5});
		$display("register test done");
		host.wr(8'h0C, 16'h0000);
		host.wr(8'h18, 16'h0010);
		for (int k = 0; k < 4; k++) host.wr(8'h1A, 16'h1100 + 16'(k));
		rdc(8'h18, 16'h0014);
		host.wr(8'h18, 16'h0010);
		for (int k = 0; k < 4; k++) rdc(8'h1A, 16'h1100 + 16'(k));
		host.wr(8'h0C, 16'h4000);
		host.wr(8'h18, 16'h0020);
		host.wr(8'h1A, 16'hAAAA);
		host.wr(8'h1A, 16'h5555);
		rdc(8'h1A, 16'h5555);
		rdc(8'h18, 16'h0020);
		host.wr(8'h18, 16'h0012);
		idle_view_switch = 1'b1;
		repeat (4) @(negedge clk);
		cmp(pat_out, 16'h1102);
		idle_view_switch = 1'b0;
		$display("host access test done");
		host.wr(8'h14, 16'hBEEF);
		host.wr(8'h16, 16'h1234);
		host.wr(8'h12, 16'h0008);
		host.wr(8'h18, 16'h0010);
		rdc(8'h1A, 16'h1100);
		host.wr(8'h0E, 16'h0000);
		host.wr(8'h10, 16'h0064);
		cycle_mode_bit = 1'b0;
		run_enable = 1'b1;
		repeat (4) @(negedge clk);
		host.wr(8'h12, 16'h0008);
		cmp(pat_out, 16'h1234);
		cmp(pat_oe, 16'hFFFF);
		cmp({15'h0000, word_strobe}, 16'h0001);
		rdc(8'h1A, 16'h1234);
		host.wr(8'h18, 16'h0011);
		rdc(8'h1A, 16'hBEEF);
		host.wr(8'h0C, 16'hFFFF);
		rdc(8'h0C, 16'h4000);
		@(negedge clk);
		run_enable = 1'b0;
		cycle_mode_bit = 1'b1;
		seq_start_ptr = 15'h0002;
		seq_end_ptr = 15'h0002;
		$display("patch test done");
		host.wr(8'h0C, 16'h0000);
		host.wr(8'h18, 16'h0004);
		host.wr(8'h1A, PD);
		host.wr(8'h1A, PT);
		host.wr(8'h10, 16'h0014);
		for (int i = 0; i < 6; i++) begin
			operating_kind_bit = (i == 5);
			host.wr(8'h0C, {4'h8, MPW[i], 4'hD, PSC[i]});
			run_enable = 1'b1;
			cnt = 0;
			last = 0;
			for (int c = 0; c < 3000 && seq_done !== 1'b1; c++) begin
				@(posedge clk);
				#1;
				if (word_strobe === 1'b1) begin
					cmp(pat_out, unpk(W[i], cnt));
					cmp(pat_oe, ~PT);
					if (cnt > 0) cmp(16'((c - last) / 2), 16'h0083);
					cnt++;
					last = c;
				end
			end
			cmp(16'(cnt), 16'(N[i]));
			cmp({15'h0000, seq_done}, 16'h0001);
			repeat (300) @(negedge clk);
			run_enable = 1'b0;
			$display("unpack test %0d done", i);
		end
		final_report();
	end
endmodule : tb_pog_top
